// File: core/pth_consts.vh
`ifndef PTH_CONSTS_VH
`define PTH_CONSTS_VH

// ****************************************
// System clock and frame rate
// ****************************************
`define PTH_CLK_MHZ 100
`define PTH_FRAME_HZ 8000

// ****************************************
// Bit clock rate select codes
// ****************************************
`define PTH_RATE_1M024 3'h0
`define PTH_RATE_1M536 3'h1
`define PTH_RATE_2M048 3'h2
`define PTH_RATE_3M072 3'h3
`define PTH_RATE_4M096 3'h4
`define PTH_RATE_6M144 3'h5
`define PTH_RATE_8M192 3'h6

// ****************************************
// Bit clock periods per 8 kHz frame
// ****************************************
`define PTH_BITS_1M024 11'h080
`define PTH_BITS_1M536 11'h0C0
`define PTH_BITS_2M048 11'h100
`define PTH_BITS_3M072 11'h180
`define PTH_BITS_4M096 11'h200
`define PTH_BITS_6M144 11'h300
`define PTH_BITS_8M192 11'h400

// ****************************************
// Field widths and reset values
// ****************************************
`define PTH_CLK_SLOT_W 3
`define PTH_TS_W 7
`define PTH_BYTE_LAST 3'h7
`define PTH_SPI_LAST 3'h7
`define PTH_BITPOS_RST 11'h000
`define PTH_BITPOS_MAX 11'h7FF
`define PTH_FIFO_DEPTH 8
`define PTH_FIFO_AW 3
`define PTH_FIFO_W 17

`endif

// File: core/pth_host_port.v
`timescale 1ns/1ps
`default_nettype none
`include "pth_consts.vh"

// ****************************************
// Receive sample FIFO
// ****************************************
module pth_fifo #(
  parameter W  = `PTH_FIFO_W,
  parameter D  = `PTH_FIFO_DEPTH,
  parameter AW = `PTH_FIFO_AW
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         rst_b_i,
  // Fill side
  input  wire         in_valid_i,
  output reg          in_ready_o,
  input  wire [W-1:0] in_data_i,
  // Drain side
  output reg          out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW-1:0] wr;
  reg  [AW-1:0] rd;
  reg  [AW:0]   cnt;
  wire          push;
  wire          pop;
  wire [AW:0]   next_cnt;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data_o = mem[rd];

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr] <= in_data_i;
    end
  end

  // Flags kept as flops so the drain side sees clean levels
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr <= {AW{1'b0}};
      rd <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr <= (wr == D - 1) ? {AW{1'b0}} : wr + 1'b1;
      end
      if (pop) begin
        rd <= (rd == D - 1) ? {AW{1'b0}} : rd + 1'b1;
      end
      cnt <= next_cnt;
      in_ready_o <= (next_cnt != D);
      out_valid_o <= (next_cnt != {(AW+1){1'b0}});
    end
  end
endmodule

module pth_host_port (
  // Clock and reset
  input  wire                 clk_i,
  input  wire                 rst_b_i,
  // Mode strap and status
  input  wire                 mode_strap_i,
  input  wire                 status_pending_i,
  output reg                  pcm_mode_o,
  output reg                  host_int_b_o,
  // PCM highway pins
  input  wire                 pcm_bclk_i,
  input  wire                 frame_sync_pulse_i,
  input  wire                 pcm_rx_in_i,
  output reg                  pcm_tx_out_o,
  output reg                  pcm_tx_oe_o,
  // PCM configuration
  input  wire [2:0]           bclk_rate_i,
  input  wire                 linear_i,
  input  wire                 wideband_i,
  input  wire                 tx_neg_edge_i,
  input  wire [2:0]           tx_clk_slot_i,
  input  wire [2:0]           rx_clk_slot_i,
  input  wire [6:0]           tx_slot_ch0_i,
  input  wire [6:0]           tx_slot_ch1_i,
  input  wire [6:0]           rx_slot_ch0_i,
  input  wire [6:0]           rx_slot_ch1_i,
  // Transmit samples
  input  wire [15:0]          tx_sample_ch0_i,
  input  wire [15:0]          tx_sample_ch1_i,
  // Receive samples
  output wire                 rx_valid_o,
  input  wire                 rx_ready_i,
  output wire [15:0]          rx_data_o,
  output wire                 rx_chan_o,
  output reg                  rx_overrun_o,
  // SPI pins
  input  wire                 ctrl_serial_clock_i,
  input  wire                 ctrl_sel_b_i,
  input  wire                 ctrl_mosi_i,
  output reg                  ctrl_miso_o,
  output reg                  ctrl_miso_oe_o,
  // SPI user side
  output reg  [7:0]           ctrl_rx_byte_o,
  output reg                  ctrl_rx_valid_o,
  output reg                  ctrl_rx_is_cmd_o,
  input  wire [3:0]           ctrl_cmd_len_i,
  input  wire [7:0]           ctrl_tx_byte_i,
  output reg                  ctrl_tx_load_o
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg  [6:0]  sync1;
  reg  [6:0]  sync2;
  reg  [6:0]  sync3;
  reg         strap_seen;
  wire        bclk_rise;
  wire        bclk_fall;
  wire        fs_s;
  reg         fs_prev;
  wire        rxd_s;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        sel_s;
  wire        sel_assert;
  wire        sel_release;
  wire        mosi_s;

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      // Strap path keeps running so its level is ready at release
      sync1 <= {mode_strap_i, 6'h3F};
      sync2 <= {sync1[6], 6'h3F};
      sync3 <= 7'h7F;
    end else begin
      sync1 <= {mode_strap_i, ctrl_mosi_i, ctrl_sel_b_i, ctrl_serial_clock_i,
                pcm_rx_in_i, frame_sync_pulse_i, pcm_bclk_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign bclk_rise = sync2[0] & ~sync3[0];
  assign bclk_fall = ~sync2[0] & sync3[0];
  assign fs_s = sync2[1];
  assign rxd_s = sync2[2];
  assign sclk_rise = sync2[3] & ~sync3[3];
  assign sclk_fall = ~sync2[3] & sync3[3];
  assign sel_s = ~sync2[4];
  assign sel_assert = ~sync2[4] & sync3[4];
  assign sel_release = sync2[4] & ~sync3[4];
  assign mosi_s = sync2[5];

  // ****************************************
  // Strap capture and interrupt
  // ****************************************
  // Strap caught once after release, never under reset itself
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      strap_seen <= 1'b0;
      pcm_mode_o <= 1'b0;
      host_int_b_o <= 1'b1;
    end else begin
      if (!strap_seen) begin
        strap_seen <= 1'b1;
        pcm_mode_o <= sync2[6];
      end
      host_int_b_o <= ~(status_pending_i & pcm_mode_o);
    end
  end

  // ****************************************
  // Slot grid
  // ****************************************
  reg  [10:0] bitpos;
  reg         framed;
  reg  [10:0] frame_bits;
  wire [10:0] next_bitpos;
  wire [7:0]  half_slots;
  wire [10:0] tx_base;
  wire [10:0] tx_pos;
  wire [10:0] rx_pos;

  always @* begin
    case (bclk_rate_i)
      `PTH_RATE_1M024: frame_bits = `PTH_BITS_1M024;
      `PTH_RATE_1M536: frame_bits = `PTH_BITS_1M536;
      `PTH_RATE_2M048: frame_bits = `PTH_BITS_2M048;
      `PTH_RATE_3M072: frame_bits = `PTH_BITS_3M072;
      `PTH_RATE_4M096: frame_bits = `PTH_BITS_4M096;
      `PTH_RATE_6M144: frame_bits = `PTH_BITS_6M144;
      default:         frame_bits = `PTH_BITS_8M192;
    endcase
  end

  assign half_slots = {1'b0, frame_bits[10:4]};
  // Saturate so a missing frame sync never wraps into a live slot
  assign next_bitpos = (fs_s & ~fs_prev) ? `PTH_BITPOS_RST :
                       (bitpos == `PTH_BITPOS_MAX) ? bitpos : bitpos + 11'h001;
  assign tx_base = tx_neg_edge_i ? next_bitpos : bitpos;
  assign tx_pos = tx_base - {8'h00, tx_clk_slot_i};
  assign rx_pos = bitpos - {8'h00, rx_clk_slot_i};

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      bitpos <= `PTH_BITPOS_MAX;
      framed <= 1'b0;
      fs_prev <= 1'b1;
    end else if (bclk_fall && pcm_mode_o) begin
      bitpos <= next_bitpos;
      // Sync level kept per falling edge; the pin moves on the rising one
      fs_prev <= fs_s;
      if (fs_s & ~fs_prev) begin
        framed <= 1'b1;
      end
    end
  end

  // Returns {hit, last byte of sample}; slot count caps channels
  function [1:0] slot_hit;
    input [7:0] slot;
    input [6:0] ts;
    input [7:0] half;
    input       lin;
    input       wb;
    reg   [7:0] rel;
    begin
      rel = slot - {1'b0, ts};
      if (wb && rel >= half) begin
        rel = rel - half;
      end
      if (lin || wb) begin
        slot_hit = {(rel <= 8'h01), (rel == 8'h01)};
      end else begin
        slot_hit = {(rel == 8'h00), 1'b1};
      end
    end
  endfunction

  wire [1:0] tx_hit0;
  wire [1:0] tx_hit1;
  wire [1:0] rx_hit0;
  wire [1:0] rx_hit1;
  wire [7:0] tx_byte;
  wire [2:0] tx_bit;
  wire       tx_evt;

  assign tx_hit0 = slot_hit(tx_pos[10:3], tx_slot_ch0_i, half_slots, linear_i, wideband_i);
  assign tx_hit1 = slot_hit(tx_pos[10:3], tx_slot_ch1_i, half_slots, linear_i, wideband_i);
  assign rx_hit0 = slot_hit(rx_pos[10:3], rx_slot_ch0_i, half_slots, linear_i, wideband_i);
  assign rx_hit1 = slot_hit(rx_pos[10:3], rx_slot_ch1_i, half_slots, linear_i, wideband_i);
  assign tx_byte = tx_hit0[1] ? (tx_hit0[0] ? tx_sample_ch0_i[7:0] : tx_sample_ch0_i[15:8])
                              : (tx_hit1[0] ? tx_sample_ch1_i[7:0] : tx_sample_ch1_i[15:8]);
  assign tx_bit = `PTH_BYTE_LAST - tx_pos[2:0];
  assign tx_evt = tx_neg_edge_i ? bclk_fall : bclk_rise;

  // ****************************************
  // Transmit drive
  // ****************************************
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      pcm_tx_out_o <= 1'b0;
      pcm_tx_oe_o <= 1'b0;
    end else if (!pcm_mode_o || !framed) begin
      pcm_tx_out_o <= 1'b0;
      pcm_tx_oe_o <= 1'b0;
    end else if (tx_evt) begin
      if (tx_hit0[1] || tx_hit1[1]) begin
        pcm_tx_out_o <= tx_byte[tx_bit];
        pcm_tx_oe_o <= 1'b1;
      end else begin
        pcm_tx_out_o <= 1'b0;
        pcm_tx_oe_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // Receive capture
  // ****************************************
  reg  [7:0]  rx_shift;
  reg  [7:0]  rx_high;
  reg         push_v;
  reg  [16:0] push_d;
  wire        fifo_ready;
  wire [7:0]  rx_byte;
  wire        rx_ch;
  wire [1:0]  rx_hit;

  assign rx_byte = {rx_shift[6:0], rxd_s};
  assign rx_ch = ~rx_hit0[1];
  assign rx_hit = rx_hit0[1] ? rx_hit0 : rx_hit1;

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      rx_shift <= 8'h00;
      rx_high <= 8'h00;
      push_v <= 1'b0;
      push_d <= 17'h00000;
      rx_overrun_o <= 1'b0;
    end else begin
      rx_overrun_o <= 1'b0;
      if (push_v && fifo_ready) begin
        push_v <= 1'b0;
      end
      if (bclk_fall && pcm_mode_o && framed && rx_hit[1]) begin
        rx_shift <= rx_byte;
        if (rx_pos[2:0] == `PTH_BYTE_LAST) begin
          if (!rx_hit[0]) begin
            rx_high <= rx_byte;
          end else begin
            // A new sample wins over the clearing of push_v as the FIFO takes the old one
            push_v <= 1'b1;
            push_d <= {rx_ch, (linear_i | wideband_i) ? rx_high : 8'h00, rx_byte};
            rx_overrun_o <= push_v & ~fifo_ready;
          end
        end
      end
    end
  end

  pth_fifo #(
    .W  (`PTH_FIFO_W),
    .D  (`PTH_FIFO_DEPTH),
    .AW (`PTH_FIFO_AW)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push_v),
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_d),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  ({rx_chan_o, rx_data_o})
  );

  // ****************************************
  // SPI control slave
  // ****************************************
  reg  [2:0]  spi_cnt;
  reg  [7:0]  spi_in;
  reg  [7:0]  spi_out;
  reg  [3:0]  bytes_left;
  reg         await_len;

  // Works for modes 0 and 3 alike: no edge is counted before a rise
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      spi_cnt <= 3'h0;
      spi_in <= 8'h00;
      spi_out <= 8'h00;
      bytes_left <= 4'h0;
      await_len <= 1'b0;
      ctrl_rx_byte_o <= 8'h00;
      ctrl_rx_valid_o <= 1'b0;
      ctrl_rx_is_cmd_o <= 1'b0;
      ctrl_tx_load_o <= 1'b0;
      ctrl_miso_o <= 1'b0;
      ctrl_miso_oe_o <= 1'b0;
    end else begin
      ctrl_rx_valid_o <= 1'b0;
      ctrl_tx_load_o <= 1'b0;
      ctrl_miso_oe_o <= sel_s & pcm_mode_o;
      ctrl_miso_o <= spi_out[7];
      if (await_len) begin
        await_len <= 1'b0;
        bytes_left <= ctrl_cmd_len_i;
      end
      if (!pcm_mode_o || sel_release) begin
        spi_cnt <= 3'h0;
      end else if (sel_assert) begin
        spi_cnt <= 3'h0;
        spi_out <= ctrl_tx_byte_i;
        ctrl_tx_load_o <= 1'b1;
      end else if (sel_s && sclk_rise) begin
        spi_in <= {spi_in[6:0], mosi_s};
        spi_cnt <= spi_cnt + 3'h1;
        if (spi_cnt == `PTH_SPI_LAST) begin
          ctrl_rx_byte_o <= {spi_in[6:0], mosi_s};
          ctrl_rx_valid_o <= 1'b1;
          // Data bytes survive a select release mid-command
          ctrl_rx_is_cmd_o <= (bytes_left == 4'h0);
          if (bytes_left == 4'h0) begin
            await_len <= 1'b1;
          end else begin
            bytes_left <= bytes_left - 4'h1;
          end
          spi_out <= ctrl_tx_byte_i;
          ctrl_tx_load_o <= 1'b1;
        end
      end else if (sel_s && sclk_fall && spi_cnt != 3'h0) begin
        spi_out <= {spi_out[6:0], 1'b0};
      end
    end
  end
endmodule

`default_nettype wire

// File: sim/pth_pcm_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// PCM highway host model
// ****************************************
module pth_pcm_host (
  // Bench side
  input  wire logic         tx_neg_i,
  input  wire logic [127:0] rx_pat_i,
  // Highway
  output var  logic         bclk_o,
  output var  logic         fs_o,
  output var  logic         rx_o,
  input  wire logic         tx_i,
  input  wire logic         tx_oe_i
);
  logic [6:0]   pos;
  logic [127:0] rec;
  logic [127:0] rec_oe;
  initial begin
    bclk_o = 1'b0;
    fs_o = 1'b0;
    rx_o = 1'b0;
    pos = 7'h7C;
    rec_oe = 128'h0;
    // Edges kept off the system clock's edges, no sampling race
    #2;
    forever begin
      #62.5 bclk_o = ~bclk_o;
    end
  end
  // Bits launched on rising edge, one sync period per frame
  always @(posedge bclk_o) begin
    fs_o <= (pos == 7'h7F);
    rx_o <= rx_pat_i[pos];
  end
  always @(negedge bclk_o) begin
    pos <= fs_o ? 7'h00 : pos + 7'h01;
  end
  // Sample opposite to the drive edge
  always @(bclk_o) begin
    if (bclk_o == tx_neg_i) begin
      rec[pos] <= tx_i;
      rec_oe[pos] <= tx_oe_i;
    end
  end
endmodule
`default_nettype wire

// File: sim/pth_host_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host port checker
// ****************************************
module pth_host_port_asserts (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  // Mode and status
  input wire logic        pcm_mode_o,
  input wire logic        status_pending_i,
  input wire logic        host_int_b_o,
  // PCM
  input wire logic        pcm_bclk_i,
  input wire logic        frame_sync_pulse_i,
  input wire logic        pcm_tx_out_o,
  input wire logic        pcm_tx_oe_o,
  input wire logic        tx_neg_edge_i,
  input wire logic        rx_valid_o,
  input wire logic        rx_ready_i,
  input wire logic [15:0] rx_data_o,
  input wire logic        rx_chan_o,
  // SPI
  input wire logic        ctrl_sel_b_i,
  input wire logic        ctrl_miso_oe_o,
  input wire logic        ctrl_rx_valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic fs_seen;
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      fs_seen <= 1'b0;
    end else if (frame_sync_pulse_i) begin
      fs_seen <= 1'b1;
    end
  end
  property p_mode_oe;
    pcm_tx_oe_o |-> pcm_mode_o;
  endproperty
  a_mode_oe: assert property (p_mode_oe) else $error("tx enable outside pcm mode");
  property p_fs_first;
    pcm_tx_oe_o |-> fs_seen;
  endproperty
  a_fs_first: assert property (p_fs_first) else $error("tx before frame sync");
  property p_tx_edge;
    $rose(pcm_tx_oe_o) |-> ($past(pcm_bclk_i, 2) != tx_neg_edge_i)
      && ($past(pcm_bclk_i, 6) == tx_neg_edge_i);
  endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("slot start on wrong edge");
  property p_tx_bit;
    pcm_tx_oe_o && $past(pcm_tx_oe_o) && $changed(pcm_tx_out_o)
      |-> $past(pcm_bclk_i, 2) != tx_neg_edge_i;
  endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("tx bit moved off edge");
  property p_rx_hold;
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o) && $stable(rx_chan_o);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx word lost");
  property p_int;
    host_int_b_o == !$past(status_pending_i && pcm_mode_o);
  endproperty
  a_int: assert property (p_int) else $error("interrupt level wrong");
  property p_miso_oe;
    ctrl_sel_b_i [*7] |-> !ctrl_miso_oe_o;
  endproperty
  a_miso_oe: assert property (p_miso_oe) else $error("miso driven unselected");
  property p_miso_on;
    (!ctrl_sel_b_i) [*7] |-> ctrl_miso_oe_o == pcm_mode_o;
  endproperty
  a_miso_on: assert property (p_miso_on) else $error("miso enable wrong while selected");
  property p_no_byte;
    ctrl_sel_b_i [*8] |-> !ctrl_rx_valid_o;
  endproperty
  a_no_byte: assert property (p_no_byte) else $error("byte without select");
  property p_byte;
    ctrl_rx_valid_o |-> pcm_mode_o && !$past(ctrl_sel_b_i, 5) ##1 !ctrl_rx_valid_o;
  endproperty
  a_byte: assert property (p_byte) else $error("bad byte strobe");
endmodule
bind pth_host_port pth_host_port_asserts chk_u (.*);
`default_nettype wire

// File: sim/pth_host_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host port bench
// ****************************************
module pth_host_port_bench;
  logic clk_i, rst_b_i, mode_strap_i, status_pending_i, pcm_mode_o, host_int_b_o;
  logic pcm_bclk_i, frame_sync_pulse_i, pcm_rx_in_i, pcm_tx_out_o, pcm_tx_oe_o;
  logic linear_i, wideband_i, tx_neg_edge_i, rx_valid_o, rx_ready_i, rx_chan_o;
  logic [2:0] bclk_rate_i, tx_clk_slot_i, rx_clk_slot_i;
  logic [6:0] tx_slot_ch0_i, tx_slot_ch1_i, rx_slot_ch0_i, rx_slot_ch1_i;
  logic [15:0] tx_sample_ch0_i, tx_sample_ch1_i, rx_data_o;
  logic rx_overrun_o, ctrl_serial_clock_i, ctrl_sel_b_i, ctrl_mosi_i, ctrl_miso_o;
  logic ctrl_miso_oe_o, ctrl_rx_valid_o, ctrl_rx_is_cmd_o, ctrl_tx_load_o, ov_seen;
  logic [7:0] ctrl_rx_byte_o, ctrl_tx_byte_i, got;
  logic [3:0] ctrl_cmd_len_i;
  logic [127:0] rx_pat;
  logic [16:0] rq[$];
  logic [8:0] sq[$], eq[$];
  int n_errors, compares, cyc, rem, pops, n1;
  pth_pcm_host host_u (.tx_neg_i(tx_neg_edge_i), .rx_pat_i(rx_pat), .bclk_o(pcm_bclk_i),
    .fs_o(frame_sync_pulse_i), .rx_o(pcm_rx_in_i), .tx_i(pcm_tx_out_o), .tx_oe_i(pcm_tx_oe_o));
  pth_host_port dut_u (.*);
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Monitors and hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (rx_valid_o === 1'b1 && rx_ready_i) begin
      rq.push_back({rx_chan_o, rx_data_o});
      pops++;
    end
    if (ctrl_rx_valid_o === 1'b1) sq.push_back({ctrl_rx_is_cmd_o, ctrl_rx_byte_o});
    if (ctrl_tx_load_o === 1'b1) n1++;
    if (rx_overrun_o === 1'b1) ov_seen = 1'b1;
    if (cyc == 60000) begin
      n_errors++;
      results;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] byte_at(input logic [127:0] v, input int st);
    for (int k = 0; k < 8; k++) byte_at[7-k] = v[st+k];
  endfunction
  // Strap stable three cycles before release
  task automatic do_reset(input logic s);
    rst_b_i <= 1'b0;
    mode_strap_i <= s;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rem = 0;
    sq.delete();
    eq.delete();
  endtask
  // Config changes under reset so no slot is cut mid-byte
  task automatic pcm_test(input int m);
    int nb, ns, sp, t0, r0, st, c, s;
    logic [15:0] smp, e;
    logic [16:0] last;
    nb = (m > 1) ? 2 : 1;
    ns = (m == 3) ? 2 : 1;
    sp = (m == 3) ? 2 : 7;
    t0 = $urandom % ((m == 3) ? 4 : 6);
    r0 = $urandom % ((m == 3) ? 4 : 6);
    {linear_i, wideband_i, tx_neg_edge_i} <= {m > 1, m == 3, m == 1};
    {tx_clk_slot_i, rx_clk_slot_i} <= 6'($urandom);
    {tx_slot_ch0_i, tx_slot_ch1_i} <= {7'(t0), 7'(t0 + sp)};
    {rx_slot_ch0_i, rx_slot_ch1_i} <= {7'(r0), 7'(r0 + sp)};
    {tx_sample_ch0_i, tx_sample_ch1_i} <= $urandom;
    rx_pat <= {$urandom, $urandom, $urandom, $urandom};
    rx_ready_i <= 1'b1;
    do_reset(1'b1);
    repeat (3) @(posedge frame_sync_pulse_i);
    repeat (20) @(posedge clk_i);
    check($countones(host_u.rec_oe), 16 * nb * ns);
    for (c = 0; c < 2; c++) begin
      smp = c ? tx_sample_ch1_i : tx_sample_ch0_i;
      for (s = 0; s < ns * nb; s++) begin
        st = ((c ? t0 + sp : t0) + (s / nb) * 8 + s % nb) * 8 + tx_clk_slot_i;
        check(byte_at(host_u.rec, st), (nb == 2 && s % 2 == 0) ? smp[15:8] : smp[7:0]);
      end
      st = ((c ? r0 + sp : r0) + (ns - 1) * 8) * 8 + rx_clk_slot_i;
      e = (nb == 2) ? {byte_at(rx_pat, st), byte_at(rx_pat, st + 8)} : byte_at(rx_pat, st);
      last = 17'h1FFFF;
      foreach (rq[i]) if (rq[i][16] == c[0]) last = rq[i];
      check(last, {c[0], e});
    end
    $display("pcm test %0d done", m);
  endtask
  task automatic spi_byte(input logic [7:0] mo, input int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      ctrl_serial_clock_i <= 1'b0;
      ctrl_mosi_i <= mo[i];
      repeat (5) @(posedge clk_i);
      got = {got[6:0], ctrl_miso_o};
      ctrl_serial_clock_i <= 1'b1;
      repeat (5) @(posedge clk_i);
    end
    if (nb == 8 && mode_strap_i) begin
      eq.push_back({rem == 0, mo});
      rem = (rem == 0) ? 2 : rem - 1;
      check(got, ctrl_tx_byte_i);
    end
  endtask
  task automatic spi_win(input logic idle, input int n, input int nb);
    ctrl_serial_clock_i <= idle;
    repeat (5) @(posedge clk_i);
    ctrl_sel_b_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(ctrl_miso_oe_o, mode_strap_i);
    for (int j = 0; j < n; j++) spi_byte(8'($urandom), nb);
    ctrl_serial_clock_i <= idle;
    repeat (5) @(posedge clk_i);
    ctrl_sel_b_i <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
  initial begin
    {rst_b_i, mode_strap_i, status_pending_i, rx_ready_i, ov_seen} = 5'h08;
    {linear_i, wideband_i, tx_neg_edge_i, bclk_rate_i} = 6'h00;
    {tx_slot_ch0_i, tx_slot_ch1_i, rx_slot_ch0_i, rx_slot_ch1_i} = 28'h0;
    {tx_clk_slot_i, rx_clk_slot_i, tx_sample_ch0_i, tx_sample_ch1_i} = 38'h0;
    {ctrl_serial_clock_i, ctrl_sel_b_i, ctrl_mosi_i, ctrl_tx_byte_i} = 11'h200;
    ctrl_cmd_len_i = 4'h2;
    rx_pat = 128'h0;
    void'($urandom(32'hB956));
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    for (int m = 0; m < 4; m++) pcm_test(m);
    rx_ready_i <= 1'b0;
    ov_seen = 1'b0;
    repeat (6) @(posedge frame_sync_pulse_i);
    repeat (20) @(posedge clk_i);
    pops = 0;
    rx_ready_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    check(ov_seen, 1'b1);
    check(pops inside {8, 9}, 1'b1);
    check(rx_valid_o, 1'b0);
    $display("fifo test done");
    ctrl_tx_byte_i <= 8'($urandom);
    for (int k = 0; k < 3; k++) spi_win(1'b0, 1, 8);
    ctrl_tx_byte_i <= 8'($urandom);
    spi_win(1'b1, 6, 8);
    spi_win(1'b0, 1, 5);
    spi_win(1'b0, 1, 8);
    check(sq.size(), eq.size());
    foreach (eq[i]) check(sq[i], eq[i]);
    check(n1, 16);
    $display("spi test done");
    do_reset(1'b0);
    status_pending_i <= 1'b1;
    check(pcm_mode_o, 1'b0);
    repeat (2) @(posedge frame_sync_pulse_i);
    check($countones(host_u.rec_oe), 0);
    check(host_int_b_o, 1'b1);
    spi_win(1'b0, 1, 8);
    check(sq.size(), 0);
    do_reset(1'b1);
    check(host_int_b_o, 1'b0);
    status_pending_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(host_int_b_o, 1'b1);
    $display("strap test done");
    results;
  end
endmodule
`default_nettype wire
